// file: logic/sptf_regs.svh
// Offsets, field positions, reset values and timing counts of the phase-1 serial link.
// Assumes a single 125 MHz system clock on both ends of the link.
`ifndef SPTF_REGS_SVH
`define SPTF_REGS_SVH

// System clock and master serial clock timing
`define SPTF_CLK_PERIOD_NS 8
`define SPTF_SCLK_PERIOD_NS 160
`define SPTF_HALF_CYCLES ((`SPTF_SCLK_PERIOD_NS / 2 + `SPTF_CLK_PERIOD_NS - 1) / `SPTF_CLK_PERIOD_NS)

// Frame length
`define SPTF_BITS 8
`define SPTF_LAST_EDGE 4'hf
`define SPTF_LAST_BIT 3'h7

// Register byte offsets on the AXI4-Lite side
`define SPTF_ADDR_W 5
`define SPTF_DATA_OFS 5'h00
`define SPTF_CTRL_OFS 5'h04
`define SPTF_STAT_OFS 5'h08
`define SPTF_MASK_OFS 5'h0c

// Control fields
`define SPTF_CTRL_EN 0
`define SPTF_CTRL_CPOL 1
`define SPTF_CTRL_RST 2'h0

// Status and mask fields
`define SPTF_ST_RXDONE 0
`define SPTF_ST_TXEMPTY 1
`define SPTF_ST_MODE_FAULT_FLAG 2
`define SPTF_STAT_RST 3'h2
`define SPTF_MASK_RST 3'h0

// AXI responses
`define SPTF_RESP_OKAY 2'h0
`define SPTF_RESP_SLVERR 2'h2

`endif

// file: logic/sptf_pkg.sv
// Types shared by both ends of the phase-1 serial link.
// Assumes sptf_regs.svh supplies the numeric constants.
package sptf_pkg;

  typedef enum logic [1:0] {M_IDLE, M_SETUP, M_SHIFT, M_HOLD} sptf_mst_state_t;

  typedef enum logic {S_IDLE, S_BUSY} sptf_slv_state_t;

endpackage

// file: logic/sptf_link_if.sv
// Four-wire serial link between the master end and the slave end.
// Assumes the slave releases the data-out wire; an undriven wire reads high.
`timescale 1ns/100ps
interface sptf_link_if;
  logic sclk;
  logic mosi;
  logic ss_n;
  logic miso_out;
  logic miso_oe;
  logic miso;

  // Resolved slave-out wire, pulled high when released
  assign miso = miso_oe ? miso_out : 1'h1;

  modport master (output sclk, output mosi, output ss_n, input miso);
  modport slave (input sclk, input mosi, input ss_n, output miso_out, output miso_oe);
endinterface

// file: logic/sptf_master.sv
// Master end of the phase-1 link: makes the serial clock and select, shifts one byte per start.
// Assumes start is a one-cycle pulse from logic on clk, ignored while busy.
`timescale 1ns/100ps
`include "sptf_regs.svh"
module sptf_master (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [7:0] tx_data,
  input wire logic cpol,
  input wire logic hold_select,
  output logic busy,
  output logic done,
  output logic [7:0] rx_data,
  sptf_link_if.master link
);
  sptf_pkg::sptf_mst_state_t state_ff;
  sptf_pkg::sptf_mst_state_t nxt_state;
  logic [3:0] half_cnt_ff;
  logic [3:0] edge_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] rx_data_ff;
  logic sclk_ff;
  logic mosi_ff;
  logic ss_n_ff;
  logic done_ff;
  logic miso_meta_ff;
  logic miso_sync_ff;

  // Half-period tick and edge kind
  wire tick = (half_cnt_ff == 4'(`SPTF_HALF_CYCLES - 1));
  wire trailing = edge_cnt_ff[0];
  wire [7:0] shifted = {shift_ff[6:0], miso_sync_ff};

  assign busy = (state_ff != sptf_pkg::M_IDLE);
  assign done = done_ff;
  assign rx_data = rx_data_ff;
  assign link.sclk = sclk_ff;
  assign link.mosi = mosi_ff;
  assign link.ss_n = ss_n_ff;

  // Two flops on the returning data, it comes from the far end
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      miso_meta_ff <= 1'h1;
      miso_sync_ff <= 1'h1;
    end
    else if (ce)
    begin
      miso_meta_ff <= link.miso;
      miso_sync_ff <= miso_meta_ff;
    end

  // Next state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      sptf_pkg::M_IDLE: if (start) nxt_state = sptf_pkg::M_SETUP;
      sptf_pkg::M_SETUP: if (tick) nxt_state = sptf_pkg::M_SHIFT;
      sptf_pkg::M_SHIFT: if (tick && edge_cnt_ff == `SPTF_LAST_EDGE) nxt_state = sptf_pkg::M_HOLD;
      sptf_pkg::M_HOLD: if (tick) nxt_state = sptf_pkg::M_IDLE;
      default: nxt_state = sptf_pkg::M_IDLE;
    endcase
  end

  // State and half-period divider; divider restarts on every start
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      state_ff <= sptf_pkg::M_IDLE;
      half_cnt_ff <= 4'h0;
    end
    else if (ce)
    begin
      state_ff <= nxt_state;
      half_cnt_ff <= (busy && !tick) ? half_cnt_ff + 4'h1 : 4'h0;
    end

  // Serial clock, data out and shift register
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      sclk_ff <= 1'h0;
      mosi_ff <= 1'h0;
      shift_ff <= 8'h00;
      edge_cnt_ff <= 4'h0;
    end
    else if (ce)
    begin
      if (state_ff == sptf_pkg::M_IDLE)
      begin
        sclk_ff <= cpol; // Idle level follows polarity
        edge_cnt_ff <= 4'h0;
        if (start)
          shift_ff <= tx_data; // Start loads tx_data into the shift register
      end
      else if ((state_ff == sptf_pkg::M_SETUP || state_ff == sptf_pkg::M_SHIFT) && tick)
      begin
        edge_cnt_ff <= edge_cnt_ff + 4'h1;
        if (state_ff == sptf_pkg::M_SETUP || !trailing)
        begin
          sclk_ff <= ~cpol; // First edge leaves the idle level
          mosi_ff <= shift_ff[7]; // Data out changes on odd edges, and
        end
        else
        begin
          sclk_ff <= cpol;
          shift_ff <= shifted; // Sample on even edges
        end
      end
    end

  // Select, completion pulse and received byte
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ss_n_ff <= 1'h1;
      done_ff <= 1'h0;
      rx_data_ff <= 8'h00;
    end
    else if (ce)
    begin
      done_ff <= 1'h0;
      if (state_ff == sptf_pkg::M_IDLE && start)
        ss_n_ff <= 1'h0;
      else if (state_ff == sptf_pkg::M_IDLE && !hold_select)
        ss_n_ff <= 1'h1;
      if (state_ff == sptf_pkg::M_SHIFT && tick && edge_cnt_ff == `SPTF_LAST_EDGE)
        rx_data_ff <= shifted;
      // Select may stay low into the next byte
      if (state_ff == sptf_pkg::M_HOLD && tick)
      begin
        ss_n_ff <= ~hold_select;
        done_ff <= 1'h1;
      end
    end
endmodule

// file: logic/sptf_slave.sv
// Slave end of the phase-1 link with its AXI4-Lite register file and level interrupt.
// Assumes the link wires are asynchronous to clk and slow enough for two-flop sampling.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "sptf_regs.svh"
module sptf_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  sptf_link_if.slave link
);
  // One-hot register select: {mask, status, ctrl, data}, zero when unmapped
  function automatic logic [3:0] reg_sel(input logic [4:0] addr);
    logic [4:0] word;
    word = {addr[4:2], 2'h0};
    reg_sel = {word == `SPTF_MASK_OFS, word == `SPTF_STAT_OFS, word == `SPTF_CTRL_OFS, word == `SPTF_DATA_OFS};
  endfunction

  sptf_pkg::sptf_slv_state_t state_ff;
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic sclk_d_ff;
  logic [7:0] shift_ff;
  logic [7:0] txd_ff;
  logic [7:0] rxd_ff;
  logic pend_ff;
  logic [2:0] cnt_ff;
  logic miso_ff;
  logic [1:0] ctrl_ff;
  logic [2:0] status_ff;
  logic [2:0] mask_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [4:0] aw_addr_ff;
  logic [7:0] w_data_ff;
  logic w_lane_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;

  // Synchronised link wires: bit 0 clock, bit 1 select, bit 2 data in
  wire sclk_s = sync_ff[0];
  wire ss_s = sync_ff[1];
  wire mosi_s = sync_ff[2];
  wire en = ctrl_ff[`SPTF_CTRL_EN];
  wire cpol = ctrl_ff[`SPTF_CTRL_CPOL];

  // Edge decode; a deselected slave sees no edges at all
  wire selected = en & ~ss_s;
  wire lead = selected & (sclk_d_ff == cpol) & (sclk_s != cpol);
  wire trail = selected & (sclk_d_ff != cpol) & (sclk_s == cpol);
  wire idle = (state_ff == sptf_pkg::S_IDLE);
  wire start = idle & lead;
  wire last = ~idle & trail & (cnt_ff == `SPTF_LAST_BIT);
  wire mode_fault_flag_ev = ~idle & en & ss_s;
  wire load_ev = idle & pend_ff & ~start; // and
  wire [7:0] shifted = {shift_ff[6:0], mosi_s};

  // Bus decode
  wire wr_do = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire [3:0] wr_sel = reg_sel(aw_addr_ff);
  wire wr_ok = |wr_sel;
  wire wr_lane = wr_do & w_lane_ff;
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire [3:0] rd_sel = reg_sel(s_axi_araddr);
  wire data_wr = wr_lane & wr_sel[0];
  wire stat_rd = rd_fire & rd_sel[2];
  wire [2:0] st_set = {mode_fault_flag_ev, load_ev, last};
  wire [2:0] st_clr = stat_rd ? status_ff : 3'h0;
  wire [31:0] rd_word = rd_sel[0] ? {24'h0, rxd_ff} :
                        rd_sel[1] ? {30'h0, ctrl_ff} :
                        rd_sel[2] ? {29'h0, status_ff} :
                        rd_sel[3] ? {29'h0, mask_ff} : 32'h0;

  // Ready only while enabled so no beat is taken while state is frozen
  assign s_axi_awready = ce & ~aw_got_ff;
  assign s_axi_wready = ce & ~w_got_ff;
  assign s_axi_arready = ce & ~rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign irq = |(status_ff & mask_ff);
  assign link.miso_out = miso_ff;
  assign link.miso_oe = selected; // Only the selected slave drives, and

  // Two flops on every link wire, then a delayed clock copy for edges
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      meta_ff <= 3'h2;
      sync_ff <= 3'h2;
      sclk_d_ff <= 1'h0;
    end
    else if (ce)
    begin
      meta_ff <= {link.mosi, link.ss_n, link.sclk};
      sync_ff <= meta_ff;
      sclk_d_ff <= sclk_s;
    end

  // Transfer state; select may stay low between bytes
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      state_ff <= sptf_pkg::S_IDLE;
      cnt_ff <= 3'h0;
    end
    else if (ce)
    begin
      if (start)
        state_ff <= sptf_pkg::S_BUSY;
      else if (last || mode_fault_flag_ev || !en)
        state_ff <= sptf_pkg::S_IDLE;
      if (idle)
        cnt_ff <= 3'h0;
      else if (trail)
        cnt_ff <= cnt_ff + 3'h1; // Eight samples per byte
    end

  // Shift register and data out; reload only between transfers
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      shift_ff <= 8'h00;
      miso_ff <= 1'h0;
    end
    else if (ce)
    begin
      if (lead)
        miso_ff <= shift_ff[7]; // MSB on the first edge, then on odd edges, and
      if (~idle & trail)
        shift_ff <= shifted; // Sample on even edges
      else if (load_ev)
        shift_ff <= txd_ff; // Held byte moves in after the transfer
    end

  // Transmit holding register; a write landing after the first edge waits
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      txd_ff <= 8'h00;
      pend_ff <= 1'h0;
      rxd_ff <= 8'h00;
    end
    else if (ce)
    begin
      if (data_wr)
        txd_ff <= w_data_ff;
      pend_ff <= data_wr | (pend_ff & ~load_ev);
      if (last)
        rxd_ff <= shifted;
    end

  // Control, mask and sticky status; a set in the clearing cycle wins
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ctrl_ff <= `SPTF_CTRL_RST;
      mask_ff <= `SPTF_MASK_RST;
      status_ff <= `SPTF_STAT_RST;
    end
    else if (ce)
    begin
      if (wr_lane && wr_sel[1])
        ctrl_ff <= w_data_ff[1:0];
      if (wr_lane && wr_sel[3])
        mask_ff <= w_data_ff[2:0];
      status_ff <= (status_ff & ~st_clr) | st_set;
    end

  // Write channels are taken independently, the write acts once both are held
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      aw_got_ff <= 1'h0;
      w_got_ff <= 1'h0;
      aw_addr_ff <= 5'h00;
      w_data_ff <= 8'h00;
      w_lane_ff <= 1'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_addr_ff <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_ff <= s_axi_wdata[7:0];
        w_lane_ff <= s_axi_wstrb[0];
      end
      aw_got_ff <= (aw_got_ff & ~(bvalid_ff & s_axi_bready)) | (s_axi_awvalid & s_axi_awready);
      w_got_ff <= (w_got_ff & ~(bvalid_ff & s_axi_bready)) | (s_axi_wvalid & s_axi_wready);
    end

  // Write response and read data
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      bvalid_ff <= 1'h0;
      bresp_ff <= `SPTF_RESP_OKAY;
      rvalid_ff <= 1'h0;
      rresp_ff <= `SPTF_RESP_OKAY;
      rdata_ff <= 32'h0;
    end
    else if (ce)
    begin
      if (wr_do)
      begin
        bvalid_ff <= 1'h1;
        bresp_ff <= wr_ok ? `SPTF_RESP_OKAY : `SPTF_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_ff <= 1'h0;
      if (rd_fire)
      begin
        rvalid_ff <= 1'h1;
        rdata_ff <= rd_word;
        rresp_ff <= (|rd_sel) ? `SPTF_RESP_OKAY : `SPTF_RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_ff <= 1'h0;
    end
endmodule

// file: tb/sptf_link_monitor.sv
// Timing checker for the master-to-slave link of the bench.
// Assumes plain copies of the link wires, sampled on the system clock.
`timescale 1ns/100ps
module sptf_link_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic miso
);
  logic sclk_q_ff;
  logic idle_lvl_ff;
  logic [3:0] edge_cnt_ff;
  wire sclk_moved;

  // Edge seen on the serial clock
  assign sclk_moved = sclk != sclk_q_ff;

  // Edges per select window; wraps, so a held select over many bytes still ends on 0
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_q_ff <= 1'h0;
      idle_lvl_ff <= 1'h0;
      edge_cnt_ff <= 4'h0;
    end
    else
    begin
      sclk_q_ff <= sclk;
      edge_cnt_ff <= ss_n ? 4'h0 : edge_cnt_ff + {3'h0, sclk_moved};
      if (ss_n)
        idle_lvl_ff <= sclk;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Sync lag of up to three cycles allowed before release
  desel_release_a: assert property (ss_n [*4] |-> !miso_oe)
    else $error("slave output enabled while deselected");
  sel_drive_a: assert property (!ss_n && $changed(sclk) |-> miso_oe)
    else $error("slave output off during an edge");
  sclk_half_a: assert property (!ss_n && $changed(sclk) |=> $stable(sclk) [*8])
    else $error("serial clock edges too close");
  first_edge_a: assert property ($fell(ss_n) |-> $stable(sclk) [*8])
    else $error("serial clock moved at select");
  edge_count_a: assert property ($rose(ss_n) |-> edge_cnt_ff == 4'h0)
    else $error("edge count not a multiple of sixteen");
  idle_level_a: assert property ($rose(ss_n) |-> sclk == idle_lvl_ff)
    else $error("serial clock not back at idle level");
  miso_change_a: assert property ($changed(miso_out) && miso_oe |-> sclk != $past(sclk, 6))
    else $error("slave output changed away from an edge");
  mosi_stable_a: assert property (!ss_n && $changed(sclk) |-> ##2 $stable(mosi) [*6])
    else $error("master output moved near sampling edge");
endmodule

// file: tb/testbench.sv
// Bench: master joined to slave 0; slave 1 faces a link driven here.
// Assumes the design files and sptf_regs.svh are on the include path.
`timescale 1ns/100ps
`include "sptf_regs.svh"
module testbench;
  logic clk, rst, ce, m_start, m_cpol, m_hold, bready, rready, c;
  logic [7:0] m_tx, got;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [1:0] awvalid, wvalid, arvalid;
  wire [1:0] awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0][1:0] bresp, rresp;
  wire [1:0][31:0] rdata;
  wire m_busy, m_done;
  wire [7:0] m_rx;
  int errors, n_checks;

  sptf_link_if link[2] ();

  // Master end has no select input of its own, so it is never pulled out of master role
  sptf_master sptf_master_inst (.clk(clk), .rst(rst), .ce(ce), .start(m_start), .tx_data(m_tx), .cpol(m_cpol),
    .hold_select(m_hold), .busy(m_busy), .done(m_done), .rx_data(m_rx), .link(link[0].master));

  // Two slaves share address and data lines; valids are per slave
  for (genvar i = 0; i < 2; i++)
  begin : g_slv
    sptf_slave sptf_slave_inst (.clk(clk), .rst(rst), .ce(ce), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid[i]), .s_axi_awready(awready[i]), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid[i]), .s_axi_wready(wready[i]), .s_axi_bresp(bresp[i]), .s_axi_bvalid(bvalid[i]),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid[i]), .s_axi_arready(arready[i]),
      .s_axi_rdata(rdata[i]), .s_axi_rresp(rresp[i]), .s_axi_rvalid(rvalid[i]), .s_axi_rready(rready),
      .irq(irq[i]), .link(link[i].slave));
  end

  sptf_link_monitor sptf_link_monitor_inst (.clk(clk), .rst(rst), .sclk(link[0].sclk), .mosi(link[0].mosi),
    .ss_n(link[0].ss_n), .miso_out(link[0].miso_out), .miso_oe(link[0].miso_oe), .miso(link[0].miso));

  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait step; a stuck handshake ends the run
  task automatic guard(inout int n);
    n++;
    if (n > 500)
    begin
      errors++;
      $display("unexpected handshake: expected answer, seen none");
      results();
    end
  endtask

  task automatic wr(input int s, input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid[s] <= 1'h1;
    wvalid[s] <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(negedge clk);
      ta = awready[s];
      tw = wready[s];
      tb = bvalid[s];
      if (tb === 1'h1)
        chk("write response", er, bresp[s]);
      @(posedge clk);
      if (ta)
        awvalid[s] <= 1'h0;
      if (tw)
        wvalid[s] <= 1'h0;
      guard(n);
    end
    while (tb !== 1'h1);
    bready <= 1'h0;
  endtask

  task automatic rd(input int s, input logic [4:0] a, input logic [31:0] ed, input logic [31:0] msk,
                    input logic [1:0] er);
    int n;
    logic ta, tb;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid[s] <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(negedge clk);
      ta = arready[s];
      tb = rvalid[s];
      if (tb === 1'h1)
      begin
        chk("read data", ed, rdata[s] & msk);
        chk("read response", er, rresp[s]);
      end
      @(posedge clk);
      if (ta)
        arvalid[s] <= 1'h0;
      guard(n);
    end
    while (tb !== 1'h1);
    rready <= 1'h0;
  endtask

  task automatic m_xfer(input logic [7:0] tx, input logic hold);
    int n;
    n = 0;
    @(posedge clk);
    m_tx <= tx;
    m_hold <= hold;
    m_start <= 1'h1;
    @(posedge clk);
    m_start <= 1'h0;
    do
    begin
      @(negedge clk);
      guard(n);
    end
    while (m_done !== 1'h1);
  endtask

  // Bench-made link clock, 80 ns period, starts low, runs only inside a frame; an odd edge count leaves it high
  task automatic l_frame(input logic [7:0] tx, input int edges);
    for (int i = 0; i < edges; i++)
    begin
      repeat (5) @(posedge clk);
      link[1].sclk <= ~link[1].sclk;
      if (i % 2 == 0)
        link[1].mosi <= tx[7 - i / 2];
      else
        got[7 - i / 2] = link[1].miso;
    end
  endtask

  initial
  begin
    {rst, ce, m_start, m_cpol, m_hold, bready, rready} = 7'h60;
    {m_tx, awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
    wstrb = 4'hf;
    link[1].sclk = 1'h0;
    link[1].mosi = 1'h0;
    link[1].ss_n = 1'h1;
    rst = 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    rd(0, `SPTF_STAT_OFS, 32'h2, 32'hffffffff, `SPTF_RESP_OKAY);
    rd(0, `SPTF_MASK_OFS, 32'h0, 32'hffffffff, `SPTF_RESP_OKAY);
    rd(0, `SPTF_CTRL_OFS, 32'h0, 32'hffffffff, `SPTF_RESP_OKAY);
    rd(0, 5'h10, 32'h0, 32'hffffffff, `SPTF_RESP_SLVERR);
    wr(0, 5'h14, 32'h0, `SPTF_RESP_SLVERR);
    $display("test registers done");
    // Both clock polarities, data both ways, interrupt masked then raised on the first pass
    for (int p = 0; p < 2; p++)
    begin
      c = p[0];
      m_cpol <= c;
      wr(0, `SPTF_CTRL_OFS, {30'h0, c, 1'h1}, `SPTF_RESP_OKAY);
      wr(0, `SPTF_DATA_OFS, {24'h0, 7'h52, c}, `SPTF_RESP_OKAY);
      m_xfer({7'h1e, c}, 1'h0);
      chk("master rx", {7'h52, c}, m_rx);
      chk("master busy", 1'h0, m_busy);
      chk("idle sclk", c, link[0].sclk);
      rd(0, `SPTF_DATA_OFS, {7'h1e, c}, 32'hff, `SPTF_RESP_OKAY);
      chk("irq", c, irq[0]);
      wr(0, `SPTF_MASK_OFS, 32'h1, `SPTF_RESP_OKAY);
      chk("irq", 1'h1, irq[0]);
      rd(0, `SPTF_STAT_OFS, 32'h3, 32'hffffffff, `SPTF_RESP_OKAY);
      chk("irq", 1'h0, irq[0]);
    end
    $display("test polarity done");
    // Held select, late write waits for the next byte
    wr(0, `SPTF_DATA_OFS, 32'h81, `SPTF_RESP_OKAY);
    fork
      m_xfer(8'h42, 1'h1);
      begin
        repeat (40) @(posedge clk);
        chk("master busy", 1'h1, m_busy);
        wr(0, `SPTF_DATA_OFS, 32'h7e, `SPTF_RESP_OKAY);
      end
    join
    chk("first byte", 8'h81, m_rx);
    chk("select held", 1'h0, link[0].ss_n);
    m_xfer(8'h24, 1'h0);
    chk("second byte", 8'h7e, m_rx);
    rd(0, `SPTF_DATA_OFS, 32'h24, 32'hff, `SPTF_RESP_OKAY);
    $display("test back to back done");
    // Slave 1 against the bench-driven link
    wr(1, `SPTF_CTRL_OFS, 32'h1, `SPTF_RESP_OKAY);
    wr(1, `SPTF_MASK_OFS, 32'h4, `SPTF_RESP_OKAY);
    wr(1, `SPTF_DATA_OFS, 32'hc3, `SPTF_RESP_OKAY);
    link[1].ss_n <= 1'h0;
    repeat (5) @(posedge clk);
    l_frame(8'h5a, 16);
    repeat (5) @(posedge clk);
    link[1].ss_n <= 1'h1;
    link[1].mosi <= ~link[1].mosi;
    chk("slave out", 8'hc3, got);
    rd(1, `SPTF_DATA_OFS, 32'h5a, 32'hff, `SPTF_RESP_OKAY);
    rd(1, `SPTF_STAT_OFS, 32'h3, 32'hffffffff, `SPTF_RESP_OKAY);
    // Selected without clocks: no fault
    link[1].ss_n <= 1'h0;
    repeat (25) @(posedge clk);
    link[1].ss_n <= 1'h1;
    repeat (12) @(posedge clk);
    chk("irq no fault", 1'h0, irq[1]);
    // Deselect mid-byte, then clocks while deselected
    link[1].ss_n <= 1'h0;
    repeat (5) @(posedge clk);
    l_frame(8'hff, 5);
    repeat (5) @(posedge clk);
    link[1].ss_n <= 1'h1;
    repeat (12) @(posedge clk);
    chk("released miso", 1'h1, link[1].miso);
    chk("irq fault", 1'h1, irq[1]);
    l_frame(8'h00, 16);
    repeat (12) @(posedge clk);
    rd(1, `SPTF_STAT_OFS, 32'h4, 32'h5, `SPTF_RESP_OKAY);
    chk("irq cleared", 1'h0, irq[1]);
    rd(1, `SPTF_DATA_OFS, 32'h5a, 32'hff, `SPTF_RESP_OKAY);
    $display("test fault done");
    results();
  end
endmodule
